/* File: core/fp_pkg.sv */
// Purpose: Shared constants and types for the float add/multiply/range unit.
// Assumes: One clock, operands and results in the 64-bit sign/exponent/coefficient word.
// Notes: Octal exponent figures are given here in hexadecimal.
// Summary of operation
// RL1 - Add/multiply overflow: force exponent, flag error
// RL2 - Overflow interrupts only if enabled, not monitor
// RL3 - Interrupt enable writable by user-mode code
// RL4 - Add/multiply underflow: all-zero result, no flag
// RL5 - Reciprocal exponent complemented plus two, then checked
// RL6 - Reciprocal high exponent: overflow, clear coefficient top
// RL7 - Reciprocal low exponent also treated as overflow
// RL8 - Adder sums in coefficient-plus-one-bit register
// RL9 - Align smaller operand by right shift, truncate
// RL10 - Signs and opcode choose true add/subtract
// RL11 - Adder normalizes every result, adjusts exponent
// RL12 - Carry: shift right on add, end-around subtract
// RL13 - Multiply: XOR signs, add exponents, multiply coefficients
// RL14 - Short product shifted left, exponent minus one
// RL15 - Multiplier delivers only upper coefficient bits
// RL16 - Always inject nine carries at 2^-56
// RL17 - Multiply result identical with operands exchanged
// RL18 - Full rounding adds bits at 2^-50, 2^-51
// RL19 - Half precision rounds, keeps 29 top bits
// RL20 - Reciprocal operands should arrive already normalized
// RL21 - Issue may normalize by adding zero
// RL22 - Divide is reciprocal then multiply
// RL23 - 64-bit word: sign, biased exponent, coefficient
// RL24 - Zero result is all-zero word
// RL25 - Range check on final result exponent
package fp_pkg;
   localparam int COEF_W = 48;
   localparam int EXP_W = 15;
   localparam int PROD_W = 96;
   localparam int HALF_KEEP = 29;
   localparam int HALF_LOW_W = COEF_W - HALF_KEEP;
   localparam int EXP_TOP_BIT = 14;
   localparam int EXP_SIGN_BIT = 13;
   localparam int TRUNC_COL = 40;
   localparam int COMP_POS = 40;
   localparam int RND_FULL_POS = 45;
   localparam int RND_HALF_POS = 64;

   typedef struct packed {
      logic sign;
      logic [EXP_W-1:0] exp;
      logic [COEF_W-1:0] coef;
   } fp_word_t;

   typedef enum logic [5:0] {
      OP_ADD = 6'h01,
      OP_SUB = 6'h02,
      OP_MUL = 6'h04,
      OP_MUL_RND = 6'h08,
      OP_MUL_HALF = 6'h10,
      OP_RECIP = 6'h20
   } fp_op_t;

   localparam logic [EXP_W-1:0] EXP_BIAS = 15'h4000;
   localparam logic [EXP_W-1:0] EXP_OVF = 15'h6000;
   localparam logic [EXP_W-1:0] RECIP_ADJ = 15'h0002;
   localparam logic [EXP_W-1:0] RECIP_OVF_MIN = 15'h6002;
   localparam logic [EXP_W-1:0] RECIP_UNF_MAX = 15'h2001;
   localparam logic [EXP_W-1:0] SHIFT_LIMIT = 15'h0030;
   localparam logic [EXP_W-1:0] EXP_ONE = 15'h0001;
   localparam logic [PROD_W-1:0] TRUNC_KEEP = ~((96'h1 << TRUNC_COL) - 96'h1);
   localparam logic [PROD_W-1:0] MUL_COMP = 96'h9 << COMP_POS;
   localparam logic [PROD_W-1:0] RND_FULL = 96'h3 << RND_FULL_POS;
   localparam logic [PROD_W-1:0] RND_HALF = 96'h3 << RND_HALF_POS;
   localparam logic [COEF_W-1:0] HALF_MASK = ~((48'h1 << HALF_LOW_W) - 48'h1);
   localparam logic IFP_RST = 1'b0;
endpackage

/* File: core/fp_mult_core.sv */
// Purpose: Coefficient multiplier with truncation compensation and rounding.
// Assumes: Combinational, operand coefficients from the same clock domain.
// Notes: Only columns at or above the truncation point are summed.
module fp_mult_core (
   input wire logic [fp_pkg::COEF_W-1:0] coef_a_in,
   input wire logic [fp_pkg::COEF_W-1:0] coef_b_in,
   input wire fp_pkg::fp_op_t op_in,
   output logic [fp_pkg::COEF_W-1:0] coef_out,
   output logic shift_out
);
   logic [fp_pkg::PROD_W-1:0] acc;

   // Partial products, compensation, rounding, normalize and truncate
   always_comb begin
      acc = '0;
      // Column mask depends on i+j only, so swapping operands is exact [RL17]
      for (int i = 0; i < fp_pkg::COEF_W; i++) begin
         if (coef_a_in[i]) begin
            acc = acc + (({48'h0, coef_b_in} << i) & fp_pkg::TRUNC_KEEP); // [RL15]
         end
      end
      acc = acc + fp_pkg::MUL_COMP; // Nine carries always [RL16]
      if (op_in == fp_pkg::OP_MUL_RND) begin
         acc = acc + fp_pkg::RND_FULL; // [RL18]
      end
      if (op_in == fp_pkg::OP_MUL_HALF) begin
         acc = acc + fp_pkg::RND_HALF; // [RL19]
      end
      shift_out = ~acc[fp_pkg::PROD_W-1]; // Short product [RL14]
      if (shift_out) begin
         coef_out = acc[fp_pkg::PROD_W-2 -: fp_pkg::COEF_W];
      end else begin
         coef_out = acc[fp_pkg::PROD_W-1 -: fp_pkg::COEF_W]; // Upper half only [RL15]
      end
      if (op_in == fp_pkg::OP_MUL_HALF) begin
         coef_out = coef_out & fp_pkg::HALF_MASK; // Keep 29 bits [RL19]
      end
   end
endmodule

/* File: core/fp_range_check.sv */
// Purpose: Exponent range check for add, multiply and reciprocal results.
// Assumes: Exponent given is the final one for add and multiply; a reciprocal exponent arrives unadjusted.
// Notes: Reciprocal exponent adjustment is done here.
module fp_range_check (
   input wire logic sign_in,
   input wire logic [fp_pkg::EXP_W-1:0] exp_in,
   input wire logic [fp_pkg::COEF_W-1:0] coef_in,
   input wire logic is_recip_in,
   output fp_pkg::fp_word_t word_out,
   output logic ovf_out,
   output logic unf_out
);
   logic [fp_pkg::EXP_W-1:0] adj_exp;

   // Classify and force the result word
   always_comb begin
      adj_exp = ~exp_in + fp_pkg::RECIP_ADJ; // [RL5]
      word_out = '{sign: sign_in, exp: exp_in, coef: coef_in};
      unf_out = 1'b0;
      if (is_recip_in) begin
         ovf_out = (adj_exp >= fp_pkg::RECIP_OVF_MIN) || // [RL6]
                   (adj_exp <= fp_pkg::RECIP_UNF_MAX); // [RL7]
         word_out.exp = adj_exp;
         if (ovf_out) begin
            word_out.exp = fp_pkg::EXP_OVF;
            word_out.coef[fp_pkg::COEF_W-1] = 1'b0; // [RL6] [RL7]
         end
      end else begin
         ovf_out = exp_in[fp_pkg::EXP_TOP_BIT] & exp_in[fp_pkg::EXP_SIGN_BIT]; // [RL25]
         unf_out = ~exp_in[fp_pkg::EXP_TOP_BIT] & ~exp_in[fp_pkg::EXP_SIGN_BIT];
         if (ovf_out) begin
            word_out.exp = fp_pkg::EXP_OVF; // Coefficient kept [RL1]
         end else if (unf_out) begin
            word_out = '0; // [RL4] [RL24]
         end
      end
   end
endmodule

/* File: core/float_add_mult_range_unit.sv */
// Purpose: Floating add/subtract, multiply and reciprocal range datapath.
// Assumes: Operands and controls come from issue logic on CORE_CLK_IN.
// Notes: One cycle from an accepted operation to its registered result.
module float_add_mult_range_unit (
   input wire logic CORE_CLK_IN,
   input wire logic RESET_IN,
   input wire logic CLK_EN_IN,
   input wire logic OP_VALID_IN,
   input wire fp_pkg::fp_op_t OP_CODE_IN,
   input wire fp_pkg::fp_word_t OPND_A_IN,
   input wire fp_pkg::fp_word_t OPND_B_IN,
   input wire logic [fp_pkg::COEF_W-1:0] RECIP_COEF_IN,
   input wire logic MONITOR_MODE_IN,
   input wire logic MODE_WR_IN,
   input wire logic MODE_IFP_IN,
   input wire logic ERR_CLR_IN,
   output logic RESULT_VALID_OUT,
   output fp_pkg::fp_word_t RESULT_OUT,
   output logic FP_ERROR_OUT,
   output logic INT_REQ_OUT,
   output logic FP_ERR_INT_EN_OUT
);
   // Adder path signals
   logic is_sub;
   logic a_big;
   logic [fp_pkg::EXP_W-1:0] big_e;
   logic [fp_pkg::EXP_W-1:0] diff;
   logic [fp_pkg::COEF_W-1:0] big_c;
   logic [fp_pkg::COEF_W-1:0] small_c;
   logic [fp_pkg::COEF_W-1:0] small_sh;
   logic big_s;
   logic eff_sub;
   logic [fp_pkg::COEF_W:0] sum49;
   logic add_carry;
   logic [fp_pkg::COEF_W-1:0] add_mag;
   logic [fp_pkg::COEF_W-1:0] add_norm;
   logic add_s;
   logic [5:0] lz;
   logic [fp_pkg::EXP_W-1:0] add_e;

   // Multiplier path signals
   logic [fp_pkg::COEF_W-1:0] mul_c;
   logic mul_sh;
   logic [fp_pkg::EXP_W-1:0] mul_e;
   logic is_mul;

   // Result selection and range check
   logic pre_sign;
   logic [fp_pkg::EXP_W-1:0] pre_exp;
   logic [fp_pkg::COEF_W-1:0] pre_coef;
   logic is_recip;
   logic is_zero;
   fp_pkg::fp_word_t rng_word;
   fp_pkg::fp_word_t fin_word;
   logic rng_ovf;
   logic rng_unf;
   logic ovf_ev;

   // Registers
   fp_pkg::fp_word_t result_reg;
   fp_pkg::fp_word_t result_next;
   logic valid_reg;
   logic valid_next;
   logic err_reg;
   logic err_next;
   logic int_reg;
   logic int_next;
   logic ifp_reg;
   logic ifp_next;
   fp_pkg::fp_op_t last_op_reg;
   fp_pkg::fp_op_t last_op_next;

   // Count of leading zeros, full width when the value is zero
   function automatic logic [5:0] lead_zeros(input logic [fp_pkg::COEF_W-1:0] v);
      logic [5:0] n;
      logic found;
      n = 6'h00;
      found = 1'b0;
      for (int i = fp_pkg::COEF_W - 1; i >= 0; i--) begin
         if (v[i]) begin
            found = 1'b1;
         end else if (!found) begin
            n = n + 6'h01;
         end
      end
      return n;
   endfunction

   // Exponent equalization, effective operation, sum and normalization
   always_comb begin
      is_sub = (OP_CODE_IN == fp_pkg::OP_SUB);
      a_big = (OPND_A_IN.exp >= OPND_B_IN.exp);
      if (a_big) begin
         big_e = OPND_A_IN.exp; // Larger exponent kept [RL9]
         diff = OPND_A_IN.exp - OPND_B_IN.exp;
         big_c = OPND_A_IN.coef;
         small_c = OPND_B_IN.coef;
         big_s = OPND_A_IN.sign;
      end else begin
         big_e = OPND_B_IN.exp;
         diff = OPND_B_IN.exp - OPND_A_IN.exp;
         big_c = OPND_B_IN.coef;
         small_c = OPND_A_IN.coef;
         big_s = OPND_B_IN.sign ^ is_sub;
      end
      // Shifted-out bits are lost, wide shifts give zero [RL9]
      if (diff >= fp_pkg::SHIFT_LIMIT) begin
         small_sh = '0;
      end else begin
         small_sh = small_c >> diff;
      end
      eff_sub = OPND_A_IN.sign ^ OPND_B_IN.sign ^ is_sub; // [RL10]
      add_s = big_s;
      // One extra bit holds the carry [RL8]
      if (eff_sub) begin
         sum49 = {1'b0, big_c} + {1'b0, ~small_sh};
      end else begin
         sum49 = {1'b0, big_c} + {1'b0, small_sh};
      end
      add_carry = sum49[fp_pkg::COEF_W];
      if (!eff_sub) begin
         add_mag = add_carry ? sum49[fp_pkg::COEF_W:1] : sum49[fp_pkg::COEF_W-1:0]; // [RL12]
      end else if (add_carry) begin
         add_mag = sum49[fp_pkg::COEF_W-1:0] + 48'h0000_0000_0001; // End-around [RL12]
      end else begin
         add_mag = ~sum49[fp_pkg::COEF_W-1:0];
         add_s = ~big_s;
      end
      lz = lead_zeros(add_mag);
      add_norm = add_mag << lz; // [RL11]
      if (!eff_sub && add_carry) begin
         add_e = big_e + fp_pkg::EXP_ONE; // [RL12]
      end else begin
         add_e = big_e - {9'h000, lz}; // [RL11]
      end
   end

   // Coefficient product
   fp_mult_core u_mult (
      .coef_a_in(OPND_A_IN.coef),
      .coef_b_in(OPND_B_IN.coef),
      .op_in(OP_CODE_IN),
      .coef_out(mul_c),
      .shift_out(mul_sh)
   );

   // Product exponent, less one when the product was shifted
   assign mul_e = OPND_A_IN.exp + OPND_B_IN.exp - fp_pkg::EXP_BIAS
                  - {14'h0000, mul_sh}; // [RL13] [RL14]
   assign is_mul = (OP_CODE_IN == fp_pkg::OP_MUL) || (OP_CODE_IN == fp_pkg::OP_MUL_RND)
                   || (OP_CODE_IN == fp_pkg::OP_MUL_HALF);
   assign is_recip = (OP_CODE_IN == fp_pkg::OP_RECIP);

   // Pick the unit result before the range check
   always_comb begin
      pre_sign = 1'b0;
      pre_exp = '0;
      pre_coef = '0;
      is_zero = 1'b1;
      case (OP_CODE_IN)
         fp_pkg::OP_ADD, fp_pkg::OP_SUB: begin
            pre_sign = add_s;
            pre_exp = add_e;
            pre_coef = add_norm;
            is_zero = (add_mag == '0);
         end
         fp_pkg::OP_MUL, fp_pkg::OP_MUL_RND, fp_pkg::OP_MUL_HALF: begin
            pre_sign = OPND_A_IN.sign ^ OPND_B_IN.sign; // [RL13]
            pre_exp = mul_e;
            pre_coef = mul_c;
            is_zero = (mul_c == '0);
         end
         fp_pkg::OP_RECIP: begin
            pre_sign = OPND_B_IN.sign;
            pre_exp = OPND_B_IN.exp;
            pre_coef = RECIP_COEF_IN;
            is_zero = 1'b0;
         end
         default: begin
            is_zero = 1'b1;
         end
      endcase
   end

   // Range check on the final exponent
   fp_range_check u_range (
      .sign_in(pre_sign),
      .exp_in(pre_exp),
      .coef_in(pre_coef),
      .is_recip_in(is_recip),
      .word_out(rng_word),
      .ovf_out(rng_ovf),
      .unf_out(rng_unf)
   );

   // Zero add or multiply coefficient gives the all-zero word; reciprocal never does
   assign fin_word = is_zero ? '0 : rng_word; // [RL24] [RL23]
   assign ovf_ev = rng_ovf & ~is_zero; // [RL25]

   // Next state of result, flags and mode bit
   always_comb begin
      result_next = result_reg;
      last_op_next = last_op_reg;
      valid_next = OP_VALID_IN;
      int_next = OP_VALID_IN & ovf_ev & ifp_reg & ~MONITOR_MODE_IN; // [RL2]
      err_next = err_reg;
      ifp_next = ifp_reg;
      if (OP_VALID_IN) begin
         result_next = fin_word;
         last_op_next = OP_CODE_IN;
      end
      if (ERR_CLR_IN) begin
         err_next = 1'b0;
      end
      if (OP_VALID_IN && ovf_ev) begin
         err_next = 1'b1; // Set wins over clear [RL1]
      end
      if (MODE_WR_IN) begin
         ifp_next = MODE_IFP_IN; // No monitor-mode gate on writes [RL3]
      end
   end

   // State registers, frozen while the clock enable is low unless reset is high
   always_ff @(posedge CORE_CLK_IN) begin
      if (RESET_IN) begin
         result_reg <= '0;
         last_op_reg <= fp_pkg::OP_ADD;
         valid_reg <= 1'b0;
         int_reg <= 1'b0;
         err_reg <= 1'b0;
         ifp_reg <= fp_pkg::IFP_RST;
      end else if (CLK_EN_IN) begin
         result_reg <= result_next;
         last_op_reg <= last_op_next;
         valid_reg <= valid_next;
         int_reg <= int_next;
         err_reg <= err_next;
         ifp_reg <= ifp_next;
      end
   end

   // Outputs straight from registers
   assign RESULT_OUT = result_reg;
   assign RESULT_VALID_OUT = valid_reg;
   assign INT_REQ_OUT = int_reg;
   assign FP_ERROR_OUT = err_reg;
   assign FP_ERR_INT_EN_OUT = ifp_reg;

   // Checks on the registered behaviour
   default clocking cb_core @(posedge CORE_CLK_IN);
   endclocking
   default disable iff (RESET_IN);

   sequence s_take;
      CLK_EN_IN && OP_VALID_IN;
   endsequence

   sequence s_take_ovf;
      s_take ##0 ovf_ev;
   endsequence

   a_ovf_flag_exp: assert property ( // [RL1]
      s_take_ovf |=> FP_ERROR_OUT && (RESULT_OUT.exp == fp_pkg::EXP_OVF))
      else $error("overflow did not force exponent and flag");

   a_ovf_keep_coef: assert property ( // [RL1]
      s_take_ovf ##0 !is_recip |=> RESULT_OUT.coef == $past(pre_coef))
      else $error("overflow lost the computed coefficient");

   a_int_raised: assert property ( // [RL2]
      s_take_ovf ##0 (ifp_reg && !MONITOR_MODE_IN) |=> INT_REQ_OUT)
      else $error("enabled overflow gave no interrupt");

   a_int_cause: assert property ( // [RL2]
      INT_REQ_OUT |-> $past(ifp_reg) && !$past(MONITOR_MODE_IN) && FP_ERROR_OUT)
      else $error("interrupt without enabled overflow");

   a_ifp_write: assert property ( // [RL3]
      CLK_EN_IN && MODE_WR_IN |=> FP_ERR_INT_EN_OUT == $past(MODE_IFP_IN))
      else $error("enable bit write not taken");

   a_unf_zero: assert property ( // [RL4]
      s_take ##0 (!is_recip && rng_unf) |=> (RESULT_OUT == '0) && !INT_REQ_OUT)
      else $error("underflow result not zero");

   a_recip_ovf: assert property ( // [RL6]
      s_take ##0 (is_recip && rng_ovf)
      |=> !RESULT_OUT.coef[fp_pkg::COEF_W-1] && (RESULT_OUT.exp == fp_pkg::EXP_OVF))
      else $error("reciprocal overflow word wrong");

   a_add_norm: assert property ( // [RL11]
      RESULT_VALID_OUT && (last_op_reg inside {fp_pkg::OP_ADD, fp_pkg::OP_SUB})
      && (RESULT_OUT != '0) |-> RESULT_OUT.coef[fp_pkg::COEF_W-1])
      else $error("adder result not normalized");

   a_half_low: assert property ( // [RL19]
      RESULT_VALID_OUT && (last_op_reg == fp_pkg::OP_MUL_HALF)
      |-> RESULT_OUT.coef[fp_pkg::HALF_LOW_W-1:0] == '0)
      else $error("half precision low bits not zero");

   a_mul_sign: assert property ( // [RL13]
      s_take ##0 (is_mul && !is_zero && !rng_unf)
      |=> RESULT_OUT.sign == $past(OPND_A_IN.sign ^ OPND_B_IN.sign))
      else $error("product sign wrong");

   // A clear one cycle later may drop the flag, so only the next cycle is owed
   a_err_sticky: assert property ( // [RL1]
      FP_ERROR_OUT && CLK_EN_IN && !ERR_CLR_IN |=> FP_ERROR_OUT)
      else $error("error flag dropped without clear");

   a_ce_freeze: assert property (
      !CLK_EN_IN |=> $stable(RESULT_OUT) && $stable(FP_ERROR_OUT) && $stable(INT_REQ_OUT))
      else $error("state moved while clock enable low");
endmodule

/* File: tb/fp_issue_model.sv */
// Purpose: Issue-side model that hands operations to the float unit.
// Assumes: Requests are launched on falling edges and held across one rising edge.
// Notes: Released operand lines show the inverse of the last value, never a stale copy.
module fp_issue_model (
   input wire logic clk_in,
   output logic op_valid_out,
   output fp_pkg::fp_op_t op_code_out,
   output fp_pkg::fp_word_t opnd_a_out,
   output fp_pkg::fp_word_t opnd_b_out,
   output logic [fp_pkg::COEF_W-1:0] recip_coef_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle values before the first request
   initial begin
      op_valid_out = 1'b0;
      op_code_out = fp_pkg::OP_ADD;
      opnd_a_out = '0;
      opnd_b_out = '0;
      recip_coef_out = '0;
   end

   // One operation: held over the taking edge, then released
   // Divisors go to the reciprocal path already normalized
   // Zero partner operand is how a value is normalized
   task automatic send(input fp_pkg::fp_op_t op, input fp_pkg::fp_word_t a,
         input fp_pkg::fp_word_t b, input logic [47:0] rc);
      @(negedge clk_in);
      op_valid_out = 1'b1;
      op_code_out = op;
      opnd_a_out = a;
      opnd_b_out = b;
      recip_coef_out = rc;
      @(posedge clk_in);
      @(negedge clk_in);
      op_valid_out = 1'b0;
      opnd_a_out = ~a;
      opnd_b_out = ~b;
      recip_coef_out = ~rc;
   endtask
endmodule

/* File: tb/float_add_mult_range_unit_bench.sv */
// Purpose: Self-checking bench for the float add/multiply/range unit.
// Assumes: Issue model sends operations; bench drives its own inputs on falling edges.
// Notes: Expected words are worked out here from the arithmetic, not read back.
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_fail++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module float_add_mult_range_unit_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [47:0] HALF = 48'h800000000000;
   logic clk, rst, ce, mon, mode_wr, mode_ifp, err_clr, op_valid;
   fp_pkg::fp_op_t op_code;
   fp_pkg::fp_word_t opnd_a, opnd_b, result;
   logic [47:0] recip_coef;
   logic res_valid, fp_err, int_req, int_en;
   int n_fail = 0;
   int compares = 0;

   // Clock, 8 ns period
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   fp_issue_model issuer (.clk_in(clk), .op_valid_out(op_valid), .op_code_out(op_code),
      .opnd_a_out(opnd_a), .opnd_b_out(opnd_b), .recip_coef_out(recip_coef));

   float_add_mult_range_unit uut (.CORE_CLK_IN(clk), .RESET_IN(rst), .CLK_EN_IN(ce),
      .OP_VALID_IN(op_valid), .OP_CODE_IN(op_code), .OPND_A_IN(opnd_a),
      .OPND_B_IN(opnd_b), .RECIP_COEF_IN(recip_coef), .MONITOR_MODE_IN(mon),
      .MODE_WR_IN(mode_wr), .MODE_IFP_IN(mode_ifp), .ERR_CLR_IN(err_clr),
      .RESULT_VALID_OUT(res_valid), .RESULT_OUT(result), .FP_ERROR_OUT(fp_err),
      .INT_REQ_OUT(int_req), .FP_ERR_INT_EN_OUT(int_en));

   function automatic fp_pkg::fp_word_t w(input logic s, input logic [14:0] e,
         input logic [47:0] c);
      w = {s, e, c};
   endfunction

   // Truncated product: kept columns, nine carries, optional round bits
   function automatic fp_pkg::fp_word_t mul_ref(input fp_pkg::fp_word_t a,
         input fp_pkg::fp_word_t b, input fp_pkg::fp_op_t op);
      logic [95:0] acc;
      logic [14:0] e;
      logic [47:0] c;
      acc = '0;
      for (int i = 0; i < 48; i++) begin
         for (int j = 0; j < 48; j++) begin
            if (i + j >= 40 && a.coef[i] && b.coef[j]) acc += 96'h1 << (i + j);
         end
      end
      acc += 96'h9 << 40;
      if (op == fp_pkg::OP_MUL_RND) acc += 96'h3 << 45;
      if (op == fp_pkg::OP_MUL_HALF) acc += 96'h3 << 64;
      e = a.exp + b.exp - 15'h4000;
      c = acc[95:48];
      if (!acc[95]) begin
         c = acc[94:47];
         e = e - 15'h0001;
      end
      if (op == fp_pkg::OP_MUL_HALF) c[18:0] = '0;
      mul_ref = w(a.sign ^ b.sign, e, c);
   endfunction

   // Send one operation and judge the word and flags that come back
   task automatic run(input fp_pkg::fp_op_t op, input fp_pkg::fp_word_t a,
         input fp_pkg::fp_word_t b, input fp_pkg::fp_word_t x, input logic [47:0] rc,
         input logic err, input logic intr);
      issuer.send(op, a, b, rc);
      `CHK("valid", 1'b1, res_valid)
      `CHK("result", x, result)
      `CHK("error", err, fp_err)
      `CHK("irq", intr, int_req)
   endtask

   task automatic set_en(input logic v);
      @(negedge clk);
      mode_wr = 1'b1;
      mode_ifp = v;
      @(negedge clk);
      mode_wr = 1'b0;
      `CHK("int_en", v, int_en)
   endtask

   task automatic clear;
      @(negedge clk);
      err_clr = 1'b1;
      @(negedge clk);
      err_clr = 1'b0;
      `CHK("error_clr", 1'b0, fp_err)
   endtask

   task automatic t_reset;
      `CHK("rst_valid", 1'b0, res_valid)
      `CHK("rst_word", 64'h0, result)
      `CHK("rst_en", 1'b0, int_en)
      `CHK("rst_err", 1'b0, fp_err)
      `CHK("rst_irq", 1'b0, int_req)
   endtask

   // Clock enable low freezes the unit, then a mid-run reset clears it
   task automatic t_freeze;
      fp_pkg::fp_word_t one, big;
      one = w(1'b0, 15'h4001, HALF);
      big = w(1'b0, 15'h6000, HALF);
      run(fp_pkg::OP_ADD, one, one, w(0, 15'h4002, HALF), '0, 0, 0);
      ce = 1'b0;
      issuer.send(fp_pkg::OP_SUB, one, one, '0);
      `CHK("frz_valid", 1'b1, res_valid)
      `CHK("frz_word", w(0, 15'h4002, HALF), result)
      ce = 1'b1;
      @(negedge clk);
      `CHK("frz_after", 1'b0, res_valid)
      `CHK("frz_hold", w(0, 15'h4002, HALF), result)
      set_en(1'b1);
      run(fp_pkg::OP_ADD, big, big, big, '0, 1, 1);
      rst = 1'b1;
      @(negedge clk);
      t_reset();
      rst = 1'b0;
   endtask

   task automatic t_add;
      fp_pkg::fp_word_t one;
      one = w(1'b0, 15'h4001, HALF);
      run(fp_pkg::OP_ADD, one, one, w(0, 15'h4002, HALF), '0, 0, 0);
      run(fp_pkg::OP_SUB, one, w(0, 15'h4000, HALF), w(0, 15'h4000, HALF), '0, 0, 0);
      run(fp_pkg::OP_ADD, one, w(1, 15'h4000, HALF), w(0, 15'h4000, HALF), '0, 0, 0);
      run(fp_pkg::OP_SUB, one, w(1, 15'h4001, HALF), w(0, 15'h4002, HALF), '0, 0, 0);
      run(fp_pkg::OP_SUB, w(0, 15'h4000, HALF), one, w(1, 15'h4000, HALF), '0, 0, 0);
      run(fp_pkg::OP_ADD, one, w(0, 15'h3FD1, HALF), one, '0, 0, 0);
      run(fp_pkg::OP_ADD, one, w(0, 15'h3FD2, HALF), w(0, 15'h4001, HALF | 48'h1), '0, 0, 0);
      run(fp_pkg::OP_ADD, w(0, 15'h4030, 48'h1), '0, one, '0, 0, 0);
      run(fp_pkg::OP_SUB, one, one, '0, '0, 0, 0);
   endtask

   task automatic t_range;
      fp_pkg::fp_word_t big;
      big = w(1'b0, 15'h6000, HALF);
      set_en(1'b0);
      run(fp_pkg::OP_ADD, big, big, big, '0, 1, 0);
      clear;
      set_en(1'b1);
      run(fp_pkg::OP_ADD, big, big, big, '0, 1, 1);
      mon = 1'b1;
      run(fp_pkg::OP_ADD, big, big, big, '0, 1, 0);
      mon = 1'b0;
      clear;
      set_en(1'b0);
      run(fp_pkg::OP_ADD, w(0, 15'h1000, HALF), w(0, 15'h1000, HALF), '0, '0, 0, 0);
      run(fp_pkg::OP_MUL, big, w(0, 15'h4000, HALF), w(0, 15'h5FFF, HALF), '0, 0, 0);
      run(fp_pkg::OP_MUL, big, w(0, 15'h4001, HALF), big, '0, 1, 0);
      clear;
   endtask

   task automatic t_mul;
      fp_pkg::fp_word_t a, b;
      fp_pkg::fp_op_t ops [3] = '{fp_pkg::OP_MUL, fp_pkg::OP_MUL_RND, fp_pkg::OP_MUL_HALF};
      run(fp_pkg::OP_MUL, w(1, 15'h4001, HALF), w(0, 15'h4001, HALF),
         w(1, 15'h4001, HALF), '0, 0, 0);
      for (int k = 0; k < 6; k++) begin
         a = w(k[0], 15'h4000, k[0] ? 48'hFFFFFFFFFFFF : 48'h800000000001);
         b = w(1'b0, 15'h4003, k[0] ? 48'hAAAAAAAAAAAB : 48'hC00000000003);
         run(ops[k / 2], a, b, mul_ref(a, b, ops[k / 2]), '0, 0, 0);
         run(ops[k / 2], b, a, mul_ref(a, b, ops[k / 2]), '0, 0, 0);
      end
   endtask

   task automatic t_recip;
      logic [14:0] ein [5] = '{15'h4001, 15'h2000, 15'h5FFF, 15'h1FFF, 15'h6000};
      logic [14:0] eout [5] = '{15'h4000, 15'h6001, 15'h2002, 15'h6000, 15'h6000};
      for (int k = 0; k < 5; k++) begin
         run(fp_pkg::OP_RECIP, w(0, 15'h4001, HALF), w(k == 0, ein[k], HALF),
            w(k == 0, eout[k], k > 2 ? 48'h555555555555 : 48'hD55555555555),
            48'hD55555555555, k > 2, 0);
         clear;
      end
   endtask

   task automatic summarize;
      $display("Checks %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Main sequence: reset for 20 cycles, then each scenario in turn
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      mon = 1'b0;
      mode_wr = 1'b0;
      mode_ifp = 1'b0;
      err_clr = 1'b0;
      repeat (20) @(negedge clk);
      t_reset();
      rst = 1'b0;
      t_add();
      t_range();
      t_mul();
      t_recip();
      t_freeze();
      summarize();
   end

   // Watchdog: scenarios need about 120 cycles, allow 3000
   initial begin
      #(3000 * 8);
      n_fail++;
      summarize();
   end
endmodule
